// File: timer_section_pkg.sv
// Package of constants for the reader timer section block.
// Assumes a 32-bit AXI4-Lite register bus; each register sits in one word.
package timer_section_pkg;

  // ==========================================================================
  // Register indices and byte addresses
  // ==========================================================================
  localparam logic [5:0] IDX_RUN_CONTROL = 6'h0E;
  localparam logic [5:0] IDX_TIMER0_CONTROL = 6'h0F;
  localparam logic [5:0] IDX_RELOAD_HIGH = 6'h10;
  localparam logic [5:0] IDX_RELOAD_LOW = 6'h11;
  localparam logic [5:0] IDX_COUNT_HIGH = 6'h12;
  localparam logic [5:0] IDX_COUNT_LOW = 6'h13;
  localparam int BYTES_PER_REG = 4;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int RUN_FLAG_LSB = 4;
  localparam int NUM_TIMERS = 4;
  localparam int CTRL_STOP_RX_BIT = 7;
  localparam int CTRL_START_LSB = 4;
  localparam int CTRL_AUTO_RESTART_BIT = 3;
  localparam int CTRL_CLK_LSB = 0;
  localparam logic [7:0] CTRL_WRITABLE_MASK = 8'hBB;

  // ==========================================================================
  // Field codes
  // ==========================================================================
  localparam logic [1:0] START_NONE = 2'h0;
  localparam logic [1:0] START_TX_END = 2'h1;
  localparam logic [1:0] START_LFO_NO_UNDERFLOW = 2'h2;
  localparam logic [1:0] START_LFO_UNDERFLOW = 2'h3;
  localparam logic [1:0] CLK_FAST = 2'h0;
  localparam logic [1:0] CLK_SLOW = 2'h1;
  localparam logic [1:0] CLK_THIRD_TIMER = 2'h2;
  localparam logic [1:0] CLK_SECOND_TIMER = 2'h3;

  // ==========================================================================
  // Reset values and bus answers
  // ==========================================================================
  localparam logic [3:0] RUN_RESET = 4'h0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : timer_section_pkg

// File: reader_timer_section_ctrl.sv
// Timer section of a contactless reader: shared run control for four timers
// and the complete first timer, reached over an AXI4-Lite slave.
// Assumes every event input is a same-clock pulse from the core, except the
// oscillator reference level, which arrives from a pin and is synchronised.
//
// Contract
// - Run bits 7..4 change only where the written byte's enable bit is one.
// - Writing FF sets all run bits; writing F0 changes none.
// - Run bit reads one while its timer counts; enabled write starts/stops.
// - Enable bit n gates run bit n plus four.
// - Stop-on-receive stops the timer after the first four received bits.
// - Stop-on-receive is ignored in either oscillator trimming mode.
// - Start code 00 no auto start; 01 starts at transmission end.
// - Codes 10/11 trim the oscillator, edge start/stop, without/with underflow.
// - Outside start code 10, auto-restart reloads the reload value and keeps counting at zero.
// - Outside start code 10, without auto-restart the timer counts to zero and stops.
// - Every underflow raises the timer interrupt request flag.
// - Clock code 00 counts at the fast rate, 01 at the slow rate.
// - Clock code 10 counts third-timer underflows, 11 second-timer ones.
// - Each start loads the counter from reload high and low bytes.
// - Reload writes do not touch a running count.
// - Count high byte reads the live upper eight bits.
// - Count low byte reads the live lower eight bits.
module reader_timer_section_ctrl #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fast_clock_tick,
  input wire logic slow_clock_tick,
  input wire logic second_timer_underflow,
  input wire logic third_timer_underflow,
  input wire logic transmission_end,
  input wire logic first_rx_bits_received,
  input wire logic low_freq_oscillator,
  output logic second_timer_run_flag,
  output logic third_timer_run_flag,
  output logic fourth_timer_run_flag,
  output logic first_timer_run_flag,
  output logic timer_underflow_irq_flag
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [3:0] run;
    logic stop_on_receive;
    logic [1:0] start_mode_field;
    logic auto_restart;
    logic [1:0] clock_select_field;
    logic [7:0] reload_byte_high;
    logic [7:0] reload_byte_low;
    logic [15:0] count;
    logic irq;
    logic osc_meta;
    logic osc_sync;
    logic osc_prev;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Word index of a byte address; the two low address bits are ignored.
  function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] word;
    word = addr / ADDR_W'(timer_section_pkg::BYTES_PER_REG);
    reg_index = word[5:0];
  endfunction : reg_index

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] word;
    word = addr / ADDR_W'(timer_section_pkg::BYTES_PER_REG);
    is_mapped = (word >= ADDR_W'(timer_section_pkg::IDX_RUN_CONTROL)) &&
                (word <= ADDR_W'(timer_section_pkg::IDX_COUNT_LOW));
  endfunction : is_mapped

  // Control register image; reserved positions always read as zero.
  function automatic logic [7:0] ctrl_image(input state_t s);
    ctrl_image = {s.stop_on_receive, 1'b0, s.start_mode_field,
                  s.auto_restart, 1'b0, s.clock_select_field};
  endfunction : ctrl_image

  // ==========================================================================
  // Handshakes
  // ==========================================================================
  logic wr_take;
  logic rd_take;
  logic osc_rise;
  logic count_tick;
  logic lfo_mode;
  logic [15:0] reload_value;

  // Address and data are taken together; the master holds both until then.
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_q.bvalid;
  assign rd_take = s_axi_arvalid && !s_q.rvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign s_axi_arready = rd_take;

  assign osc_rise = s_q.osc_sync && !s_q.osc_prev;
  assign lfo_mode = s_q.start_mode_field[1];
  assign reload_value = {s_q.reload_byte_high, s_q.reload_byte_low};

  always_comb begin
    unique case (s_q.clock_select_field)
      timer_section_pkg::CLK_FAST: count_tick = fast_clock_tick;
      timer_section_pkg::CLK_SLOW: count_tick = slow_clock_tick;
      timer_section_pkg::CLK_THIRD_TIMER: begin
        count_tick = third_timer_underflow;
      end
      timer_section_pkg::CLK_SECOND_TIMER: begin
        count_tick = second_timer_underflow;
      end
    endcase
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    logic [5:0] widx;
    logic [5:0] ridx;
    logic [7:0] wbyte;
    logic wr_reg;
    s_d = s_q;
    widx = reg_index(s_axi_awaddr);
    ridx = reg_index(s_axi_araddr);
    wbyte = s_axi_wdata[7:0];
    wr_reg = wr_take && is_mapped(s_axi_awaddr) && s_axi_wstrb[0];
    s_d.irq = 1'b0;

    // The first flop of the pin synchroniser feeds only the second.
    s_d.osc_meta = low_freq_oscillator;
    s_d.osc_sync = s_q.osc_meta;
    s_d.osc_prev = s_q.osc_sync;

    // Counting on the selected tick.
    if (s_q.run[0] && count_tick) begin
      if (s_q.count == 16'h0000) begin
        if (s_q.start_mode_field == timer_section_pkg::START_LFO_NO_UNDERFLOW) begin
          // Trimming without underflow parks at zero until the next edge.
          s_d.count = 16'h0000;
        end else begin
          s_d.irq = 1'b1;
          if (s_q.auto_restart) begin
            s_d.count = reload_value;
          end else begin
            s_d.run[0] = 1'b0;
          end
        end
      end else begin
        s_d.count = s_q.count - 16'h0001;
      end
    end

    // Automatic stops; reception is ignored while trimming.
    if (s_q.run[0] && s_q.stop_on_receive && !lfo_mode &&
        first_rx_bits_received) begin
      s_d.run[0] = 1'b0;
    end
    if (s_q.run[0] && lfo_mode && osc_rise) begin
      s_d.run[0] = 1'b0;
    end

    // Automatic starts.
    if ((!s_q.run[0] && lfo_mode && osc_rise) ||
        (s_q.start_mode_field == timer_section_pkg::START_TX_END &&
         transmission_end)) begin
      s_d.run[0] = 1'b1;
      s_d.count = reload_value;
    end

    // Software writes win over same-cycle hardware events.
    if (wr_reg) begin
      unique case (widx)
        timer_section_pkg::IDX_RUN_CONTROL: begin
          for (int n = 0; n < timer_section_pkg::NUM_TIMERS; n++) begin
            if (wbyte[n]) begin
              s_d.run[n] = wbyte[n + timer_section_pkg::RUN_FLAG_LSB];
            end
          end
          if (wbyte[0] && wbyte[timer_section_pkg::RUN_FLAG_LSB]) begin
            s_d.count = reload_value;
          end
        end
        timer_section_pkg::IDX_TIMER0_CONTROL: begin
          s_d.stop_on_receive = wbyte[timer_section_pkg::CTRL_STOP_RX_BIT];
          s_d.start_mode_field =
            wbyte[timer_section_pkg::CTRL_START_LSB +: 2];
          s_d.auto_restart = wbyte[timer_section_pkg::CTRL_AUTO_RESTART_BIT];
          s_d.clock_select_field =
            wbyte[timer_section_pkg::CTRL_CLK_LSB +: 2];
        end
        timer_section_pkg::IDX_RELOAD_HIGH: begin
          s_d.reload_byte_high = wbyte;
        end
        timer_section_pkg::IDX_RELOAD_LOW: begin
          s_d.reload_byte_low = wbyte;
        end
        default: begin
          // Count bytes are read-only; writes are answered and dropped.
        end
      endcase
    end

    // Write response.
    if (wr_take) begin
      s_d.bvalid = 1'b1;
      s_d.bresp = is_mapped(s_axi_awaddr) ? timer_section_pkg::RESP_OKAY :
                  timer_section_pkg::RESP_SLVERR;
    end else if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // Read response; count bytes are sampled live at the address phase.
    if (rd_take) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = 32'h0000_0000;
      s_d.rresp = timer_section_pkg::RESP_OKAY;
      if (!is_mapped(s_axi_araddr)) begin
        s_d.rresp = timer_section_pkg::RESP_SLVERR;
      end else begin
        unique case (ridx)
          timer_section_pkg::IDX_RUN_CONTROL: begin
            s_d.rdata[7:0] = {s_q.run, 4'h0};
          end
          timer_section_pkg::IDX_TIMER0_CONTROL: begin
            s_d.rdata[7:0] = ctrl_image(s_q);
          end
          timer_section_pkg::IDX_RELOAD_HIGH: begin
            s_d.rdata[7:0] = s_q.reload_byte_high;
          end
          timer_section_pkg::IDX_RELOAD_LOW: begin
            s_d.rdata[7:0] = s_q.reload_byte_low;
          end
          timer_section_pkg::IDX_COUNT_HIGH: begin
            s_d.rdata[7:0] = s_q.count[15:8];
          end
          default: begin
            s_d.rdata[7:0] = s_q.count[7:0];
          end
        endcase
      end
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.run <= timer_section_pkg::RUN_RESET;
      s_q.reload_byte_high <= timer_section_pkg::RELOAD_RESET;
      s_q.reload_byte_low <= timer_section_pkg::RELOAD_RESET;
      s_q.count <= timer_section_pkg::COUNT_RESET;
      s_q.bresp <= timer_section_pkg::RESP_OKAY;
      s_q.rresp <= timer_section_pkg::RESP_OKAY;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign first_timer_run_flag = s_q.run[0];
  assign second_timer_run_flag = s_q.run[1];
  assign third_timer_run_flag = s_q.run[2];
  assign fourth_timer_run_flag = s_q.run[3];
  assign timer_underflow_irq_flag = s_q.irq;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = s_q.rdata;

endmodule : reader_timer_section_ctrl

// File: timer_section_monitor.sv
// Bus and run-control assertions for the reader timer section.
// Assumes it is bound to the top module and sees only its ports.
module timer_section_monitor #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic first_timer_run_flag,
  input wire logic second_timer_run_flag,
  input wire logic third_timer_run_flag,
  input wire logic timer_underflow_irq_flag
);
  // ======================================================
  // Helpers and assertions
  // ======================================================
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic take_w;
  logic run_w;
  logic [5:0] idx;
  assign idx = s_axi_awaddr[7:2];
  assign take_w = s_axi_awvalid && s_axi_awready;
  assign run_w = take_w && s_axi_wstrb[0] &&
    idx == timer_section_pkg::IDX_RUN_CONTROL;
  chk_write_answer: assert property (take_w |=> s_axi_bvalid)
    else $error("write not answered");
  chk_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while busy");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read not answered");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0)
    else $error("upper read bits set");
  chk_mask_off: assert property (run_w && !s_axi_wdata[2] |=>
    $stable(third_timer_run_flag)) else $error("masked bit changed");
  chk_mask_on: assert property (run_w && s_axi_wdata[1] |=>
    second_timer_run_flag == $past(s_axi_wdata[5]))
    else $error("enabled bit not loaded");
  chk_unmapped_resp: assert property (take_w && (idx < 6'h0E || idx > 6'h13)
    |=> s_axi_bresp == timer_section_pkg::RESP_SLVERR)
    else $error("unmapped write accepted");
  chk_irq_cause: assert property (timer_underflow_irq_flag |->
    $past(first_timer_run_flag)) else $error("irq while stopped");
  cover property (timer_underflow_irq_flag);
  cover property (run_w && s_axi_wdata[1]);
  cover property (s_axi_bvalid &&
    s_axi_bresp == timer_section_pkg::RESP_SLVERR);
endmodule : timer_section_monitor

bind reader_timer_section_ctrl timer_section_monitor #(.ADDR_W(ADDR_W)) mon (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .first_timer_run_flag, .second_timer_run_flag,
  .third_timer_run_flag, .timer_underflow_irq_flag);

// File: reader_timer_section_ctrl_tb.sv
// Self-checking bench for the reader timer section.
// Drives the AXI4-Lite port and the event pulses; one clock, 100 MHz.
module reader_timer_section_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] OK = timer_section_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = timer_section_pkg::RESP_SLVERR;
  logic aclk = 1'h0, aresetn = 1'h0, low_freq_oscillator = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, first_timer_run_flag, second_timer_run_flag;
  logic third_timer_run_flag, fourth_timer_run_flag, timer_underflow_irq_flag;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  // Event pulses: fast, slow, second, third underflow, tx end, rx bits.
  logic [5:0] ev = 6'h00;
  int n_mismatch = 0, n_tests = 0, n_irq = 0;
  reader_timer_section_ctrl DUT (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .fast_clock_tick(ev[0]),
    .slow_clock_tick(ev[1]), .second_timer_underflow(ev[2]),
    .third_timer_underflow(ev[3]), .transmission_end(ev[4]),
    .first_rx_bits_received(ev[5]), .low_freq_oscillator,
    .second_timer_run_flag, .third_timer_run_flag, .fourth_timer_run_flag,
    .first_timer_run_flag, .timer_underflow_irq_flag);
  always #5 aclk = ~aclk;
  always @(posedge aclk) if (timer_underflow_irq_flag === 1'h1) n_irq++;
  // ======================================================
  // Shared tasks
  // ======================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d, input logic [1:0] er = OK);
    logic aw_left;
    logic w_left;
    aw_left = 1'h1;
    w_left = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    // Each channel is released only at the edge where its own ready is high.
    while (aw_left || w_left) begin
      @(posedge aclk);
      if (aw_left && s_axi_awready === 1'h1) begin
        aw_left = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w_left && s_axi_wready === 1'h1) begin
        w_left = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    while (s_axi_bvalid !== 1'h1) @(posedge aclk);
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er = OK);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    while (s_axi_rvalid !== 1'h1) @(posedge aclk);
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask : rd
  task automatic tick(input int i, input int n);
    repeat (n) begin
      ev[i] <= 1'h1;
      @(posedge aclk);
      ev[i] <= 1'h0;
      @(posedge aclk);
    end
  endtask : tick
  task automatic summarize;
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // ======================================================
  // Scenarios
  // ======================================================
  task automatic t_mask_regs;
    for (int a = 'h38; a < 'h50; a += 4) rd(8'(a), 32'h0);
    wr(8'h38, 8'hF0);
    rd(8'h38, 32'h0);
    wr(8'h38, 8'hFF);
    rd(8'h38, 32'hF0);
    chk({fourth_timer_run_flag, third_timer_run_flag,
         second_timer_run_flag, first_timer_run_flag}, 32'hF);
    wr(8'h38, 8'h0D);
    rd(8'h38, 32'h20);
    chk(first_timer_run_flag, 1'h0);
    chk({fourth_timer_run_flag, third_timer_run_flag,
         second_timer_run_flag, first_timer_run_flag}, 32'h2);
    wr(8'h38, 8'h02);
    chk(second_timer_run_flag, 1'h0);
    // A write whose byte lane is off is answered but changes nothing.
    s_axi_wstrb <= 4'h0;
    wr(8'h38, 8'hFF);
    s_axi_wstrb <= 4'hF;
    rd(8'h38, 32'h0);
    wr(8'h3C, 8'hFF);
    rd(8'h3C, 32'hBB);
    wr(8'h48, 8'h55);
    rd(8'h48, 32'h0);
    wr(8'h00, 8'hFF, ERR);
    rd(8'h50, 32'h0, ERR);
  endtask : t_mask_regs
  task automatic t_count;
    int n;
    wr(8'h3C, 8'h00);
    wr(8'h40, 8'h01);
    wr(8'h44, 8'h03);
    wr(8'h38, 8'h11);
    tick(0, 2);
    rd(8'h48, 32'h01);
    wr(8'h44, 8'h09);
    rd(8'h4C, 32'h01);
    n = n_irq;
    tick(0, 257);
    chk(first_timer_run_flag, 1'h1);
    tick(0, 1);
    @(posedge aclk);
    chk(n_irq, n + 1);
    chk(first_timer_run_flag, 1'h0);
    wr(8'h38, 8'h11);
    rd(8'h4C, 32'h09);
  endtask : t_count
  task automatic t_restart;
    wr(8'h3C, 8'h09);
    wr(8'h40, 8'h00);
    wr(8'h44, 8'h02);
    wr(8'h38, 8'h11);
    tick(0, 3);
    rd(8'h4C, 32'h02);
    tick(1, 3);
    rd(8'h4C, 32'h02);
    tick(1, 1);
    rd(8'h4C, 32'h01);
    for (int c = 2; c < 4; c++) begin
      wr(8'h3C, 8'(c));
      wr(8'h38, 8'h11);
      tick(5 - c, 1);
      rd(8'h4C, 32'h01);
      tick(c, 1);
      rd(8'h4C, 32'h01);
    end
  endtask : t_restart
  task automatic t_start;
    int n;
    wr(8'h38, 8'h01);
    wr(8'h3C, 8'h00);
    tick(4, 1);
    chk(first_timer_run_flag, 1'h0);
    wr(8'h3C, 8'h90);
    tick(4, 1);
    rd(8'h4C, 32'h02);
    tick(5, 1);
    chk(first_timer_run_flag, 1'h0);
    wr(8'h3C, 8'h10);
    tick(4, 1);
    tick(5, 1);
    chk(first_timer_run_flag, 1'h1);
    wr(8'h38, 8'h01);
    for (int m = 'hA8; m < 'hC0; m += 'h10) begin
      wr(8'h3C, 8'(m));
      low_freq_oscillator <= 1'h1;
      repeat (4) @(posedge aclk);
      tick(5, 1);
      chk(first_timer_run_flag, 1'h1);
      // Only the trimming mode with underflow raises the flag at zero.
      n = n_irq;
      tick(0, 3);
      @(posedge aclk);
      chk(n_irq - n, 32'(m[4]));
      chk(first_timer_run_flag, 1'h1);
      low_freq_oscillator <= 1'h0;
      repeat (4) @(posedge aclk);
      low_freq_oscillator <= 1'h1;
      repeat (4) @(posedge aclk);
      chk(first_timer_run_flag, 1'h0);
      low_freq_oscillator <= 1'h0;
      repeat (4) @(posedge aclk);
    end
  endtask : t_start
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_mask_regs;
    t_count;
    t_restart;
    t_start;
    summarize;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    summarize;
  end
endmodule : reader_timer_section_ctrl_tb
